//--- test/baseband_controller.sv
`timescale 1ns/1ns
`default_nettype none
module baseband_controller (
  // clock
  input  wire logic clk_i,
  // three-wire serial pins
  output var  logic cs_n_o,
  output var  logic sclk_o,
  output var  logic din_o
);
  // serial clock stands low outside frames
  initial begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
    din_o  = 1'b0;
  end

  // top n bits, msb first; the released data line flips so a stale bit never looks valid
  task automatic send(input logic [17:0] word, input int n);
    @(negedge clk_i);
    cs_n_o = 1'b0;
    for (int i = 17; i > 17 - n; i--) begin
      @(negedge clk_i);
      din_o = word[i];
      @(negedge clk_i);
      sclk_o = 1'b1;
      @(negedge clk_i);
      sclk_o = 1'b0;
    end
    @(negedge clk_i);
    cs_n_o = 1'b1;
    din_o  = ~din_o;
  endtask
endmodule
`default_nettype wire

//--- test/rx_gain_filter_control_properties.sv
`timescale 1ns/1ns
`default_nettype none
module rx_gain_filter_checker (
  // clock and reset
  input wire logic        clk_i,
  input wire logic        reset_n_i,
  input wire logic        ce_i,
  // inputs watched
  input wire logic        cs_n_i,
  input wire logic        direction_select_i,
  input wire logic        power_down_n_i,
  input wire logic        coupling_corner_select_i,
  // outputs watched
  input wire logic        rx_enable_o,
  input wire logic        standby_o,
  input wire logic [1:0]  front_amp_gain_code_o,
  input wire logic [1:0]  front_amp_state_o,
  input wire logic [5:0]  front_amp_atten_db_o,
  input wire logic [4:0]  baseband_gain_code_o,
  input wire logic [5:0]  baseband_gain_db_o,
  input wire logic        highpass_ac_o,
  input wire logic [1:0]  highpass_corner_o,
  input wire logic [1:0]  lowpass_coarse_code_o,
  input wire logic [2:0]  lowpass_fine_code_o,
  input wire logic [6:0]  lowpass_fine_pct_o,
  input wire logic [14:0] lowpass_corner_khz_o,
  input wire logic        gain_source_select_o
);
  wire [1:0]  fc = front_amp_gain_code_o;
  wire [1:0]  cc = lowpass_coarse_code_o;
  wire [31:0] khz = cc[1] ? (cc[0] ? 32'h4650 : 32'h3A98) : (cc[0] ? 32'h2134 : 32'h1D4C);

  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  sequence frame_closed;
    !cs_n_i ##1 cs_n_i;
  endsequence

  a_rx_enable:
    assert property (ce_i |=> rx_enable_o == $past(power_down_n_i && !direction_select_i))
    else $error("receive enable wrong");
  a_standby_override:
    assert property (ce_i |=> standby_o != $past(power_down_n_i) && !(standby_o && rx_enable_o))
    else $error("standby wrong");
  a_front_decode:
    assert property (front_amp_state_o == (fc[1] ? {1'b0, !fc[0]} : 2'h2)
      && front_amp_atten_db_o == (fc[1] ? (fc[0] ? 6'h00 : 6'h10) : 6'h21))
    else $error("front amplifier decode wrong");
  a_bb_weight:
    assert property (baseband_gain_db_o == {baseband_gain_code_o, 1'b0})
    else $error("baseband gain weight wrong");
  a_hp_select:
    assert property (ce_i |=> highpass_ac_o == $past(coupling_corner_select_i)
      && (highpass_corner_o == 2'h3) == highpass_ac_o)
    else $error("highpass select wrong");
  a_fine_trim:
    assert property (lowpass_fine_code_o <= 3'h4 && lowpass_fine_pct_o == 7'h5A + 7'h05 * lowpass_fine_code_o)
    else $error("fine trim wrong");
  a_corner_calc:
    assert property ($past(reset_n_i) |-> {17'h0, lowpass_corner_khz_o} == khz * lowpass_fine_pct_o / 32'h64)
    else $error("lowpass corner wrong");
  a_select_latency:
    assert property (frame_closed |-> $stable(gain_source_select_o)[*3])
    else $error("source select changed early");
endmodule

bind rx_gain_filter_control rx_gain_filter_checker checker_inst (
  .clk_i, .reset_n_i, .ce_i, .cs_n_i, .direction_select_i, .power_down_n_i, .coupling_corner_select_i,
  .rx_enable_o, .standby_o, .front_amp_gain_code_o, .front_amp_state_o, .front_amp_atten_db_o,
  .baseband_gain_code_o, .baseband_gain_db_o, .highpass_ac_o, .highpass_corner_o,
  .lowpass_coarse_code_o, .lowpass_fine_code_o, .lowpass_fine_pct_o, .lowpass_corner_khz_o,
  .gain_source_select_o);
`default_nettype wire

//--- test/tb_rx_gain_filter_control.sv
`timescale 1ns/1ns
`default_nettype none
module tb_rx_gain_filter_control;
  logic        clk_i, reset_n_i, ce_i, dir, pd_n, hp;
  logic [6:0]  gp;
  wire         cs_n, sclk, din, rx_en, stby, hp_ac, sel;
  wire  [1:0]  fcode, fstate, hpc, coarse;
  wire  [5:0]  fatt, bbdb;
  wire  [4:0]  bbcode;
  wire  [2:0]  fine;
  wire  [6:0]  pct;
  wire  [14:0] khz;
  int          errors, checks;
  logic [4:0]  bbt [4] = '{5'h1F, 5'h00, 5'h15, 5'h0A};

  baseband_controller bbc (.clk_i(clk_i), .cs_n_o(cs_n), .sclk_o(sclk), .din_o(din));
  rx_gain_filter_control dut (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .ce_i(ce_i), .cs_n_i(cs_n), .sclk_i(sclk), .din_i(din),
    .direction_select_i(dir), .power_down_n_i(pd_n), .coupling_corner_select_i(hp),
    .gain_pin_7_i(gp[6]), .gain_pin_6_i(gp[5]), .gain_pin_5_i(gp[4]), .gain_pin_4_i(gp[3]),
    .gain_pin_3_i(gp[2]), .gain_pin_2_i(gp[1]), .gain_pin_1_i(gp[0]), .rx_enable_o(rx_en),
    .standby_o(stby), .front_amp_gain_code_o(fcode), .front_amp_state_o(fstate),
    .front_amp_atten_db_o(fatt), .baseband_gain_code_o(bbcode), .baseband_gain_db_o(bbdb),
    .highpass_ac_o(hp_ac), .highpass_corner_o(hpc), .lowpass_coarse_code_o(coarse),
    .lowpass_fine_code_o(fine), .lowpass_fine_pct_o(pct), .lowpass_corner_khz_o(khz),
    .gain_source_select_o(sel));

  task automatic compare(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %0h seen %0h", name, exp, seen);
    end
  endtask

  task automatic summarize;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // pins change at a falling edge and show after the next rising edge
  task automatic set_pins(input logic d, input logic p, input logic h, input logic [6:0] g);
    dir  = d;
    pd_n = p;
    hp   = h;
    gp   = g;
    repeat (2) @(negedge clk_i);
  endtask

  task automatic wr(input logic [3:0] a, input logic [13:0] d);
    bbc.send({d, a}, 18);
    repeat (6) @(negedge clk_i);
  endtask

  task automatic check_front(input logic [1:0] c, input logic [4:0] b);
    compare("front code", fcode, c);
    compare("front state", fstate, c[1] ? {1'b0, !c[0]} : 2'h2);
    compare("front atten", fatt, c[1] ? (c[0] ? 6'h00 : 6'h10) : 6'h21);
    compare("bb code", bbcode, b);
    compare("bb gain", bbdb, {b, 1'b0});
  endtask

  function automatic logic [31:0] corner(input logic [1:0] c, input logic [2:0] f);
    logic [31:0] k;
    logic [31:0] p;
    k = c[1] ? (c[0] ? 32'h4650 : 32'h3A98) : (c[0] ? 32'h2134 : 32'h1D4C);
    p = f > 3'h4 ? 32'h64 : 32'h5A + 32'h5 * f;
    return k * p / 32'h64;
  endfunction

  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  initial begin
    #1000000;
    errors++;
    summarize;
  end

  initial begin
    reset_n_i = 1'b0;
    ce_i = 1'b1;
    {dir, pd_n, hp, gp} = 10'h200;
    repeat (6) @(negedge clk_i);
    compare("standby", stby, 1'b1);
    reset_n_i = 1'b1;
    repeat (2) @(negedge clk_i);
    compare("source", sel, 1'b0);
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      set_pins(i[1], i[0], 1'b0, 7'h00);
      compare("rx enable", rx_en, !i[1] && i[0]);
      compare("standby", stby, !i[0]);
    end
    $display("test mode pins done");
    for (int i = 0; i < 4; i++) begin
      set_pins(1'b0, 1'b1, 1'b0, {i[1:0], bbt[i]});
      check_front(i[1:0], bbt[i]);
    end
    $display("test gain pins done");
    set_pins(1'b0, 1'b1, 1'b0, 7'h6A);
    wr(4'hB, 14'h004B);
    check_front(2'h3, 5'h0A);
    wr(4'h8, 14'h1002);
    compare("source", sel, 1'b1);
    check_front(2'h2, 5'h0B);
    set_pins(1'b0, 1'b1, 1'b0, 7'h00);
    check_front(2'h2, 5'h0B);
    bbc.send(18'h00010, 17);
    wr(4'hA, 14'h0000);
    compare("source", sel, 1'b1);
    $display("test serial source done");
    for (int c = 0; c < 4; c++) begin
      wr(4'h8, {12'h400, c[1:0]});
      for (int f = 0; f < 8; f++) begin
        wr(4'h7, {f[1:0], 9'h000, f[2:0]});
        compare("coarse", coarse, c);
        compare("fine code", fine, f > 4 ? 2 : f);
        compare("fine pct", pct, f > 4 ? 100 : 90 + 5 * f);
        compare("corner", khz, corner(c[1:0], f[2:0]));
        compare("hp corner", hpc, f[0] ? 2'h1 : {f[1], 1'b0});
      end
    end
    set_pins(1'b0, 1'b1, 1'b1, 7'h00);
    compare("hp corner", hpc, 2'h3);
    $display("test filter done");
    wr(4'h8, 14'h0000);
    set_pins(1'b0, 1'b1, 1'b0, 7'h3F);
    compare("source", sel, 1'b0);
    check_front(2'h1, 5'h1F);
    $display("test pin return done");
    // with the enable low every output must hold its last value
    ce_i = 1'b0;
    set_pins(1'b1, 1'b0, 1'b1, 7'h00);
    compare("frozen rx enable", rx_en, 1'b1);
    compare("frozen standby", stby, 1'b0);
    compare("frozen hp ac", hp_ac, 1'b0);
    compare("frozen bb code", bbcode, 5'h1F);
    ce_i = 1'b1;
    set_pins(1'b1, 1'b0, 1'b1, 7'h00);
    compare("rx enable", rx_en, 1'b0);
    compare("standby", stby, 1'b1);
    compare("hp ac", hp_ac, 1'b1);
    compare("hp corner", hpc, 2'h3);
    compare("bb code", bbcode, 5'h00);
    $display("test clock enable done");
    summarize;
  end
endmodule
`default_nettype wire

//--- verilog/front_amp_decode.v
`timescale 1ns/1ns
`default_nettype none
`include "rx_gain_filter_defs.vh"

module front_amp_decode (
  // gain code
  input  wire [1:0] code_i,
  // decoded state
  output reg  [1:0] state_o,
  output reg  [5:0] atten_db_o
);

  always @* begin
    if (!code_i[1]) begin
      state_o    = `FRONT_STATE_LOW;
      atten_db_o = `FRONT_ATTEN_LOW;
    end else if (code_i[0]) begin
      state_o    = `FRONT_STATE_HIGH;
      atten_db_o = `FRONT_ATTEN_HIGH;
    end else begin
      state_o    = `FRONT_STATE_MEDIUM;
      atten_db_o = `FRONT_ATTEN_MEDIUM;
    end
  end

endmodule
`default_nettype wire

//--- verilog/rx_gain_filter_control.v
`timescale 1ns/1ns
`default_nettype none
`include "rx_gain_filter_defs.vh"

module rx_gain_filter_control (
  // clock, reset, enable
  input  wire        clk_i,
  input  wire        reset_n_i,
  input  wire        ce_i,
  // three-wire serial interface
  input  wire        cs_n_i,
  input  wire        sclk_i,
  input  wire        din_i,
  // mode pins
  input  wire        direction_select_i,
  input  wire        power_down_n_i,
  input  wire        coupling_corner_select_i,
  // parallel gain pins
  input  wire        gain_pin_7_i,
  input  wire        gain_pin_6_i,
  input  wire        gain_pin_5_i,
  input  wire        gain_pin_4_i,
  input  wire        gain_pin_3_i,
  input  wire        gain_pin_2_i,
  input  wire        gain_pin_1_i,
  // operating mode
  output reg         rx_enable_o,
  output reg         standby_o,
  // front amplifier control
  output reg  [1:0]  front_amp_gain_code_o,
  output reg  [1:0]  front_amp_state_o,
  output reg  [5:0]  front_amp_atten_db_o,
  // baseband amplifier control
  output reg  [4:0]  baseband_gain_code_o,
  output reg  [5:0]  baseband_gain_db_o,
  // highpass control
  output reg         highpass_ac_o,
  output reg  [1:0]  highpass_corner_o,
  // lowpass control
  output reg  [1:0]  lowpass_coarse_code_o,
  output reg  [2:0]  lowpass_fine_code_o,
  output reg  [6:0]  lowpass_fine_pct_o,
  output reg  [14:0] lowpass_corner_khz_o,
  // register state
  output reg         gain_source_select_o
);

  // write-only registers loaded from the serial interface
  reg  [`SER_DATA_WIDTH-1:0] rx_filter_trim_register;
  reg  [`SER_DATA_WIDTH-1:0] rx_mode_config_register;
  reg  [`SER_DATA_WIDTH-1:0] rx_gain_register;

  wire                       wr_strobe;
  wire [`SER_ADDR_WIDTH-1:0] wr_addr;
  wire [`SER_DATA_WIDTH-1:0] wr_data;

  three_wire_receiver u_serial (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .ce_i      (ce_i),
    .cs_n_i    (cs_n_i),
    .sclk_i    (sclk_i),
    .din_i     (din_i),
    .write_o   (wr_strobe),
    .addr_o    (wr_addr),
    .data_o    (wr_data)
  );

  // unmapped addresses belong to other parts of the radio and are ignored here
  always @(posedge clk_i) begin
    if (!reset_n_i) begin
      rx_filter_trim_register <= `FILTER_TRIM_RESET;
      rx_mode_config_register <= `MODE_CONFIG_RESET;
      rx_gain_register        <= `GAIN_RESET;
    end else if (ce_i && wr_strobe) begin
      if (wr_addr == `ADDR_FILTER_TRIM) begin
        rx_filter_trim_register <= wr_data;
      end else if (wr_addr == `ADDR_MODE_CONFIG) begin
        rx_mode_config_register <= wr_data;
      end else if (wr_addr == `ADDR_GAIN) begin
        rx_gain_register <= wr_data;
      end
    end
  end

  // field extraction
  wire       gain_source_select  = rx_mode_config_register[`GAIN_SOURCE_BIT];
  wire [1:0] lowpass_coarse_code = rx_mode_config_register[`COARSE_HI:`COARSE_LO];
  wire [1:0] near_dc_corner_code = rx_filter_trim_register[`NEAR_DC_HI:`NEAR_DC_LO];
  wire [2:0] lowpass_fine_code   = rx_filter_trim_register[`FINE_HI:`FINE_LO];
  wire [1:0] reg_front_gain      = rx_gain_register[`FRONT_GAIN_HI:`FRONT_GAIN_LO];
  wire [4:0] reg_bb_gain         = rx_gain_register[`BB_GAIN_HI:`BB_GAIN_LO];

  wire [1:0] pin_front_gain = {gain_pin_7_i, gain_pin_6_i};
  wire [4:0] pin_bb_gain    = {gain_pin_5_i, gain_pin_4_i, gain_pin_3_i, gain_pin_2_i, gain_pin_1_i};

  // gain source selection
  reg  [1:0] next_front_gain;
  reg  [4:0] next_bb_gain;

  always @* begin
    if (gain_source_select) begin
      next_front_gain = reg_front_gain;
    end else begin
      next_front_gain = pin_front_gain;
    end
    if (gain_source_select) begin
      next_bb_gain = reg_bb_gain;
    end else begin
      next_bb_gain = pin_bb_gain;
    end
  end

  wire [1:0] next_front_state;
  wire [5:0] next_front_atten;

  front_amp_decode u_front_decode (
    .code_i     (next_front_gain),
    .state_o    (next_front_state),
    .atten_db_o (next_front_atten)
  );

  // binary weighted, 2dB per lsb above minimum
  wire [5:0] next_bb_db = {next_bb_gain, 1'b0};

  // highpass corner decode
  reg [1:0] next_hp_corner;

  always @* begin
    if (coupling_corner_select_i) begin
      next_hp_corner = `HP_CORNER_600KHZ;
    end else if (near_dc_corner_code[0]) begin
      next_hp_corner = `HP_CORNER_4KHZ;
    end else if (near_dc_corner_code[1]) begin
      next_hp_corner = `HP_CORNER_30KHZ;
    end else begin
      next_hp_corner = `HP_CORNER_100HZ;
    end
  end

  // lowpass corner decode
  reg  [14:0] coarse_khz;
  reg  [2:0]  next_fine_code;
  reg  [6:0]  next_fine_pct;
  wire [21:0] corner_product = coarse_khz * next_fine_pct;
  // divide by 100; the widest product is 18000 * 110 so 22 bits suffice
  wire [21:0] corner_quotient = corner_product / 22'd100;

  always @* begin
    case (lowpass_coarse_code)
      2'h0:    coarse_khz = `LP_COARSE_KHZ_0;
      2'h1:    coarse_khz = `LP_COARSE_KHZ_1;
      2'h2:    coarse_khz = `LP_COARSE_KHZ_2;
      default: coarse_khz = `LP_COARSE_KHZ_3;
    endcase
    // reserved trims fall back to nominal
    if (lowpass_fine_code > `FINE_CODE_MAX) begin
      next_fine_code = `FINE_CODE_NOMINAL;
    end else begin
      next_fine_code = lowpass_fine_code;
    end
    case (next_fine_code)
      3'h0:    next_fine_pct = `FINE_PCT_0;
      3'h1:    next_fine_pct = `FINE_PCT_1;
      3'h3:    next_fine_pct = `FINE_PCT_3;
      3'h4:    next_fine_pct = `FINE_PCT_4;
      default: next_fine_pct = `FINE_PCT_2;
    endcase
  end

  // registered outputs; analog controls never see combinational glitches
  always @(posedge clk_i) begin
    if (!reset_n_i) begin
      rx_enable_o           <= 1'b0;
      standby_o             <= 1'b1;
      front_amp_gain_code_o <= 2'h0;
      front_amp_state_o     <= `FRONT_STATE_LOW;
      front_amp_atten_db_o  <= `FRONT_ATTEN_LOW;
      baseband_gain_code_o  <= 5'h00;
      baseband_gain_db_o    <= 6'h00;
      highpass_ac_o         <= 1'b0;
      highpass_corner_o     <= `HP_CORNER_100HZ;
      lowpass_coarse_code_o <= 2'h0;
      lowpass_fine_code_o   <= `FINE_CODE_NOMINAL;
      lowpass_fine_pct_o    <= `FINE_PCT_2;
      lowpass_corner_khz_o  <= 15'h0000;
      gain_source_select_o  <= 1'b0;
    end else if (ce_i) begin
      standby_o             <= ~power_down_n_i;
      rx_enable_o           <= power_down_n_i & ~direction_select_i;
      front_amp_gain_code_o <= next_front_gain;
      front_amp_state_o     <= next_front_state;
      front_amp_atten_db_o  <= next_front_atten;
      baseband_gain_code_o  <= next_bb_gain;
      baseband_gain_db_o    <= next_bb_db;
      highpass_ac_o         <= coupling_corner_select_i;
      highpass_corner_o     <= next_hp_corner;
      lowpass_coarse_code_o <= lowpass_coarse_code;
      lowpass_fine_code_o   <= next_fine_code;
      lowpass_fine_pct_o    <= next_fine_pct;
      lowpass_corner_khz_o  <= corner_quotient[14:0];
      gain_source_select_o  <= gain_source_select;
    end
  end

endmodule
`default_nettype wire

//--- verilog/rx_gain_filter_defs.vh
`ifndef RX_GAIN_FILTER_DEFS_VH
`define RX_GAIN_FILTER_DEFS_VH

// serial word layout: 14 data bits then 4 address bits, msb first
`define SER_DATA_WIDTH        14
`define SER_ADDR_WIDTH        4
`define SER_WORD_WIDTH        18
`define SER_COUNT_WIDTH       5
`define SER_FRAME_BITS        5'h12

// register addresses
`define ADDR_FILTER_TRIM      4'h7
`define ADDR_MODE_CONFIG      4'h8
`define ADDR_GAIN             4'hB

// field positions
`define GAIN_SOURCE_BIT       12
`define NEAR_DC_HI            13
`define NEAR_DC_LO            12
`define COARSE_HI             1
`define COARSE_LO             0
`define FINE_HI               2
`define FINE_LO               0
`define FRONT_GAIN_HI         6
`define FRONT_GAIN_LO         5
`define BB_GAIN_HI            4
`define BB_GAIN_LO            0

// reset values
`define FILTER_TRIM_RESET     14'h0002
`define MODE_CONFIG_RESET     14'h0001
`define GAIN_RESET            14'h007F

// front amplifier gain states and attenuation in dB
`define FRONT_STATE_HIGH      2'h0
`define FRONT_STATE_MEDIUM    2'h1
`define FRONT_STATE_LOW       2'h2
`define FRONT_ATTEN_HIGH      6'h00
`define FRONT_ATTEN_MEDIUM    6'h10
`define FRONT_ATTEN_LOW       6'h21

// highpass corner selections
`define HP_CORNER_100HZ       2'h0
`define HP_CORNER_4KHZ        2'h1
`define HP_CORNER_30KHZ       2'h2
`define HP_CORNER_600KHZ      2'h3

// lowpass coarse corners in kHz
`define LP_COARSE_KHZ_0       15'h1D4C
`define LP_COARSE_KHZ_1       15'h2134
`define LP_COARSE_KHZ_2       15'h3A98
`define LP_COARSE_KHZ_3       15'h4650

// lowpass fine trim codes and percentages
`define FINE_CODE_NOMINAL     3'h2
`define FINE_CODE_MAX         3'h4
`define FINE_PCT_0            7'h5A
`define FINE_PCT_1            7'h5F
`define FINE_PCT_2            7'h64
`define FINE_PCT_3            7'h69
`define FINE_PCT_4            7'h6E

`endif

//--- verilog/three_wire_receiver.v
`timescale 1ns/1ns
`default_nettype none
`include "rx_gain_filter_defs.vh"

module three_wire_receiver (
  // clock and reset
  input  wire                        clk_i,
  input  wire                        reset_n_i,
  input  wire                        ce_i,
  // serial pins
  input  wire                        cs_n_i,
  input  wire                        sclk_i,
  input  wire                        din_i,
  // decoded write
  output reg                         write_o,
  output reg  [`SER_ADDR_WIDTH-1:0]  addr_o,
  output reg  [`SER_DATA_WIDTH-1:0]  data_o
);

  reg [`SER_WORD_WIDTH-1:0]  shift;
  reg [`SER_COUNT_WIDTH-1:0] count;
  reg                        sclk_prev;
  reg                        cs_n_prev;

  wire sclk_rise = sclk_i & ~sclk_prev;
  wire frame_end = cs_n_i & ~cs_n_prev;

  always @(posedge clk_i) begin
    if (!reset_n_i) begin
      shift     <= {`SER_WORD_WIDTH{1'b0}};
      count     <= {`SER_COUNT_WIDTH{1'b0}};
      sclk_prev <= 1'b0;
      cs_n_prev <= 1'b1;
      write_o   <= 1'b0;
      addr_o    <= {`SER_ADDR_WIDTH{1'b0}};
      data_o    <= {`SER_DATA_WIDTH{1'b0}};
    end else if (ce_i) begin
      sclk_prev <= sclk_i;
      cs_n_prev <= cs_n_i;
      write_o   <= 1'b0;
      if (cs_n_i) begin
        count <= {`SER_COUNT_WIDTH{1'b0}};
      end else if (sclk_rise) begin
        shift <= {shift[`SER_WORD_WIDTH-2:0], din_i};
        // saturate so an over-long frame is never mistaken for a whole one
        if (count != 5'h1F) begin
          count <= count + 5'h01;
        end
      end
      // short or long frames are dropped whole
      if (frame_end && count == `SER_FRAME_BITS) begin
        write_o <= 1'b1;
        data_o  <= shift[`SER_WORD_WIDTH-1:`SER_ADDR_WIDTH];
        addr_o  <= shift[`SER_ADDR_WIDTH-1:0];
      end
    end
  end

endmodule
`default_nettype wire
